// >>> rtl/bts_exec.v
// Execution sequencer for multi-register transfers, atomic swap and supervisor call
`timescale 1ns/1ps
`include "bts_map.vh"
module bts_exec (
  // Clock and reset
  input wire CLK_I,
  input wire RSTN_I,
  // Instruction issue
  input wire [31:0] INSTR_I,
  input wire [31:0] INSTR_PC_I,
  input wire INSTR_VALID_I,
  output reg BUSY_O,
  output reg DONE_O,
  output reg INTR_OPEN_O,
  output reg TRAP_SWI_O,
  output reg TRAP_ABORT_O,
  output reg PC_LOAD_O,
  output reg [31:0] PC_O,
  // Memory system
  output reg MEM_REQ_O,
  output reg MEM_WRITE_O,
  output reg MEM_BYTE_O,
  output reg MEM_LOCK_O,
  output reg [1:0] MEM_CYCLE_O,
  output reg [31:0] MEM_ADDR_O,
  output reg [31:0] MEM_WDATA_O,
  input wire [31:0] MEM_RDATA_I,
  input wire MEM_ABORT_I,
  // Register port
  input wire [7:0] BUS_ADDR_I,
  input wire [31:0] BUS_WDATA_I,
  input wire BUS_WR_I,
  input wire BUS_RD_I,
  output reg [31:0] BUS_RDATA_O
);
  localparam S_IDLE = 4'h0;
  localparam S_RDA = 4'h1;
  localparam S_RDB = 4'h2;
  localparam S_SWRD = 4'h3;
  localparam S_SWWR = 4'h4;
  localparam S_SWINT = 4'h5;
  localparam S_MXFR = 4'h6;
  localparam S_MEND = 4'h7;
  localparam S_WB = 4'h8;
  localparam S_SWI = 4'h9;
  localparam S_RET = 4'ha;
  localparam S_FIN = 4'hb;

  reg [3:0] state_r;
  reg [31:0] ins_r, csr_r, svsr_r, base_r, src_r, addr_r, wb_r, rd_data_r;
  reg [15:0] list_r;
  reg [3:0] pend_idx_r, regidx_r;
  reg pend_r, abort_r, first_r, big_r, cnt_r;
  reg rf_we_r;
  reg [4:0] rf_waddr_r, rf_raddr;
  reg [31:0] rf_wdata_r;
  wire [31:0] rf_rdata;

  function cond_ok;
    input [3:0] c;
    input [3:0] f;
    reg r;
    begin
      case (c[3:1])
        3'h0: r = f[2];
        3'h1: r = f[1];
        3'h2: r = f[3];
        3'h3: r = f[0];
        3'h4: r = f[1] & ~f[2];
        3'h5: r = f[3] == f[0];
        3'h6: r = ~f[2] & (f[3] == f[0]);
        default: r = 1'b1;
      endcase
      cond_ok = (c == 4'hf) ? 1'b0 : (r ^ c[0]) | (c == 4'he);
    end
  endfunction

  function [3:0] lowest;
    input [15:0] l;
    integer i;
    begin
      lowest = 4'h0;
      for (i = 15; i >= 0; i = i - 1)
      begin
        if (l[i])
        begin
          lowest = i[3:0];
        end
      end
    end
  endfunction

  function [5:0] popcnt;
    input [15:0] l;
    integer i;
    begin
      popcnt = 6'h0;
      for (i = 0; i < 16; i = i + 1)
      begin
        popcnt = popcnt + {5'h0, l[i]};
      end
    end
  endfunction

  // Only the link register is banked; user flag forces the unbanked copy
  function [4:0] phys;
    input [3:0] idx;
    input svc;
    input user;
    begin
      phys = (idx == `BTS_LR_IDX && svc && !user) ? `BTS_LINK_SVC : {1'b0, idx};
    end
  endfunction

  function [31:0] byte_get;
    input [31:0] w;
    input [1:0] a;
    input big;
    reg [1:0] lane;
    begin
      lane = big ? ~a : a;
      byte_get = {24'h0, w[{lane, 3'h0} +: 8]};
    end
  endfunction

  wire in_svc = csr_r[4:0] == `BTS_MODE_SVC;
  wire is_swp = INSTR_I[27:23] == 5'h02 && INSTR_I[21:20] == 2'h0 && INSTR_I[11:4] == 8'h09;
  wire is_blk = INSTR_I[27:25] == 3'h4;
  wire is_swi = INSTR_I[27:24] == 4'hf;
  wire is_ret = INSTR_I[27:20] == 8'h1b && INSTR_I[15:12] == 4'hf && INSTR_I[11:0] == 12'h00e;
  wire take = INSTR_VALID_I && cond_ok(INSTR_I[31:28], csr_r[31:28]);
  wire i_swp = ins_r[27:25] == 3'h0;
  wire i_byte = ins_r[22];
  wire i_load = ins_r[20];
  wire i_user = ins_r[22] && !(ins_r[20] && ins_r[15]);
  wire [5:0] n_regs = popcnt(ins_r[15:0]);
  wire [31:0] span = {24'h0, n_regs, 2'h0};
  wire [15:0] list_rest = list_r & (list_r - 16'h1);
  wire [3:0] cur = lowest(list_r);

  bts_regfile #(
    .DEPTH(17),
    .AW(5)
  ) u_rf (
    .clk_i(CLK_I),
    .we_i(rf_we_r),
    .waddr_i(rf_waddr_r),
    .wdata_i(rf_wdata_r),
    .raddr_i(rf_raddr),
    .rdata_o(rf_rdata)
  );

  always @*
  begin
    rf_raddr = phys(regidx_r, in_svc, 1'b0);
    case (state_r)
      S_IDLE:
      begin
        if (INSTR_VALID_I && (is_swp || is_blk || is_ret))
        begin
          rf_raddr = is_ret ? phys(`BTS_LR_IDX, in_svc, 1'b0) : {1'b0, INSTR_I[19:16]};
        end
      end
      S_RDA:
      begin
        rf_raddr = i_swp ? {1'b0, ins_r[3:0]} : phys(lowest(ins_r[15:0]), in_svc, i_user);
      end
      S_MXFR:
      begin
        rf_raddr = phys(lowest(list_rest), in_svc, i_user);
      end
      default:
      begin
        // Same banking as the software write path, so the link register reads back
        rf_raddr = phys(regidx_r, in_svc, 1'b0);
      end
    endcase
  end

  always @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      state_r <= S_IDLE;
      ins_r <= 32'h0;
      csr_r <= `BTS_CSR_RESET;
      svsr_r <= 32'h0;
      base_r <= 32'h0;
      src_r <= 32'h0;
      addr_r <= 32'h0;
      wb_r <= 32'h0;
      rd_data_r <= 32'h0;
      list_r <= 16'h0;
      pend_idx_r <= 4'h0;
      regidx_r <= 4'h0;
      pend_r <= 1'b0;
      abort_r <= 1'b0;
      first_r <= 1'b0;
      big_r <= 1'b0;
      cnt_r <= 1'b0;
      rf_we_r <= 1'b0;
      rf_waddr_r <= 5'h0;
      rf_wdata_r <= 32'h0;
      BUSY_O <= 1'b0;
      DONE_O <= 1'b0;
      INTR_OPEN_O <= 1'b1;
      TRAP_SWI_O <= 1'b0;
      TRAP_ABORT_O <= 1'b0;
      PC_LOAD_O <= 1'b0;
      PC_O <= 32'h0;
      MEM_REQ_O <= 1'b0;
      MEM_WRITE_O <= 1'b0;
      MEM_BYTE_O <= 1'b0;
      MEM_LOCK_O <= 1'b0;
      MEM_CYCLE_O <= `BTS_CYC_IDLE;
      MEM_ADDR_O <= 32'h0;
      MEM_WDATA_O <= 32'h0;
      BUS_RDATA_O <= 32'h0;
    end
    else
    begin
      rf_we_r <= 1'b0;
      DONE_O <= 1'b0;
      TRAP_SWI_O <= 1'b0;
      TRAP_ABORT_O <= 1'b0;
      PC_LOAD_O <= 1'b0;
      MEM_REQ_O <= 1'b0;
      MEM_WRITE_O <= 1'b0;
      MEM_CYCLE_O <= `BTS_CYC_IDLE;
      // Memory answers within the cycle of its request, so an abort pairs with the request now standing
      if (MEM_REQ_O && MEM_ABORT_I)
      begin
        abort_r <= 1'b1;
      end
      if (BUS_RD_I)
      begin
        case (BUS_ADDR_I)
          `BTS_OFF_CTRL: BUS_RDATA_O <= {31'h0, big_r};
          `BTS_OFF_STAT: BUS_RDATA_O <= {29'h0, abort_r, in_svc, BUSY_O};
          `BTS_OFF_CSR: BUS_RDATA_O <= csr_r;
          `BTS_OFF_SVSR: BUS_RDATA_O <= svsr_r;
          `BTS_OFF_REGIDX: BUS_RDATA_O <= {28'h0, regidx_r};
          `BTS_OFF_REGDAT: BUS_RDATA_O <= rf_rdata;
          `BTS_OFF_PC: BUS_RDATA_O <= PC_O;
          default: BUS_RDATA_O <= 32'h0;
        endcase
      end
      if (BUS_WR_I && BUS_ADDR_I == `BTS_OFF_CTRL)
      begin
        big_r <= BUS_WDATA_I[`BTS_CTRL_BIG];
      end
      if (BUS_WR_I && BUS_ADDR_I == `BTS_OFF_REGIDX)
      begin
        regidx_r <= BUS_WDATA_I[3:0];
      end
      // Core state is only writable by software while no instruction runs or arrives
      if (BUS_WR_I && state_r == S_IDLE && !INSTR_VALID_I)
      begin
        case (BUS_ADDR_I)
          `BTS_OFF_CSR: csr_r <= BUS_WDATA_I;
          `BTS_OFF_SVSR: svsr_r <= BUS_WDATA_I;
          `BTS_OFF_PC: PC_O <= BUS_WDATA_I;
          `BTS_OFF_REGDAT:
          begin
            rf_we_r <= 1'b1;
            rf_waddr_r <= phys(regidx_r, in_svc, 1'b0);
            rf_wdata_r <= BUS_WDATA_I;
          end
          default: ;
        endcase
      end
      case (state_r)
        S_IDLE:
        begin
          if (INSTR_VALID_I && !take)
          begin
            DONE_O <= 1'b1;
          end
          else if (take)
          begin
            ins_r <= INSTR_I;
            abort_r <= 1'b0;
            if (is_swp || is_blk)
            begin
              state_r <= S_RDA;
              BUSY_O <= 1'b1;
              INTR_OPEN_O <= 1'b0;
            end
            else if (is_ret)
            begin
              state_r <= S_RET;
              BUSY_O <= 1'b1;
              INTR_OPEN_O <= 1'b0;
            end
            else if (is_swi)
            begin
              // Comment field INSTR_I[23:0] is never looked at
              svsr_r <= csr_r;
              csr_r <= {csr_r[31:5], `BTS_MODE_SVC};
              rf_we_r <= 1'b1;
              rf_waddr_r <= `BTS_LINK_SVC;
              rf_wdata_r <= INSTR_PC_I + 32'h4;
              PC_O <= `BTS_SWI_VECTOR;
              PC_LOAD_O <= 1'b1;
              MEM_REQ_O <= 1'b1;
              MEM_BYTE_O <= 1'b0;
              MEM_ADDR_O <= `BTS_SWI_VECTOR;
              MEM_CYCLE_O <= `BTS_CYC_N;
              cnt_r <= 1'b0;
              state_r <= S_SWI;
              BUSY_O <= 1'b1;
              INTR_OPEN_O <= 1'b0;
            end
            else
            begin
              DONE_O <= 1'b1;
            end
          end
        end
        S_RDA:
        begin
          base_r <= rf_rdata;
          if (i_swp)
          begin
            state_r <= S_RDB;
          end
          else
          begin
            list_r <= ins_r[15:0];
            first_r <= 1'b1;
            pend_r <= 1'b0;
            // Transfers always climb from the lowest address
            if (ins_r[23])
            begin
              addr_r <= ins_r[24] ? rf_rdata + 32'h4 : rf_rdata;
              wb_r <= rf_rdata + span;
            end
            else
            begin
              addr_r <= ins_r[24] ? rf_rdata - span : rf_rdata - span + 32'h4;
              wb_r <= rf_rdata - span;
            end
            state_r <= S_MXFR;
          end
        end
        S_RDB:
        begin
          src_r <= rf_rdata;
          MEM_REQ_O <= 1'b1;
          MEM_ADDR_O <= base_r;
          MEM_BYTE_O <= i_byte;
          MEM_LOCK_O <= 1'b1;
          MEM_CYCLE_O <= `BTS_CYC_N;
          state_r <= S_SWRD;
        end
        S_SWRD:
        begin
          rd_data_r <= i_byte ? byte_get(MEM_RDATA_I, base_r[1:0], big_r) : MEM_RDATA_I;
          MEM_REQ_O <= 1'b1;
          MEM_WRITE_O <= 1'b1;
          MEM_WDATA_O <= i_byte ? {4{src_r[7:0]}} : src_r;
          MEM_LOCK_O <= 1'b1;
          MEM_CYCLE_O <= `BTS_CYC_N;
          state_r <= S_SWWR;
        end
        S_SWWR:
        begin
          // Only the read abort is visible yet, so a write abort alone still updates the destination
          if (!abort_r)
          begin
            rf_we_r <= 1'b1;
            rf_waddr_r <= {1'b0, ins_r[15:12]};
            rf_wdata_r <= rd_data_r;
          end
          MEM_LOCK_O <= 1'b0;
          MEM_CYCLE_O <= `BTS_CYC_I;
          state_r <= S_SWINT;
        end
        S_SWINT:
        begin
          MEM_CYCLE_O <= `BTS_CYC_S;
          state_r <= S_FIN;
        end
        S_MXFR, S_MEND:
        begin
          if (pend_r && !MEM_ABORT_I && !abort_r)
          begin
            if (pend_idx_r == `BTS_PC_IDX)
            begin
              PC_O <= MEM_RDATA_I;
              PC_LOAD_O <= 1'b1;
              if (ins_r[22])
              begin
                csr_r <= svsr_r;
              end
            end
            else
            begin
              rf_we_r <= 1'b1;
              rf_waddr_r <= phys(pend_idx_r, in_svc, i_user);
              rf_wdata_r <= MEM_RDATA_I;
            end
          end
          pend_r <= 1'b0;
          if (state_r == S_MXFR)
          begin
            MEM_REQ_O <= 1'b1;
            MEM_BYTE_O <= 1'b0;
            MEM_ADDR_O <= addr_r;
            MEM_WRITE_O <= !i_load;
            MEM_WDATA_O <= (cur == `BTS_PC_IDX) ? INSTR_PC_I + 32'hc : rf_rdata;
            MEM_CYCLE_O <= first_r ? `BTS_CYC_N : `BTS_CYC_S;
            first_r <= 1'b0;
            addr_r <= addr_r + 32'h4;
            list_r <= list_rest;
            pend_r <= i_load;
            pend_idx_r <= cur;
            state_r <= (list_rest == 16'h0) ? S_MEND : S_MXFR;
          end
          else
          begin
            MEM_CYCLE_O <= `BTS_CYC_I;
            state_r <= S_WB;
          end
        end
        S_WB:
        begin
          // Base ends at its written-back value when writeback is set, even after an abort; otherwise original value if a load aborted
          if (ins_r[21])
          begin
            rf_we_r <= 1'b1;
            rf_waddr_r <= {1'b0, ins_r[19:16]};
            rf_wdata_r <= wb_r;
          end
          else if (abort_r && i_load && ins_r[ins_r[19:16]])
          begin
            rf_we_r <= 1'b1;
            rf_waddr_r <= {1'b0, ins_r[19:16]};
            rf_wdata_r <= base_r;
          end
          state_r <= S_FIN;
        end
        S_SWI:
        begin
          MEM_REQ_O <= 1'b1;
          MEM_ADDR_O <= cnt_r ? `BTS_SWI_VECTOR + 32'h8 : `BTS_SWI_VECTOR + 32'h4;
          MEM_CYCLE_O <= `BTS_CYC_S;
          cnt_r <= 1'b1;
          state_r <= cnt_r ? S_FIN : S_SWI;
        end
        S_RET:
        begin
          PC_O <= rf_rdata;
          PC_LOAD_O <= 1'b1;
          csr_r <= svsr_r;
          state_r <= S_FIN;
        end
        S_FIN:
        begin
          DONE_O <= 1'b1;
          TRAP_ABORT_O <= abort_r;
          TRAP_SWI_O <= ins_r[27:24] == 4'hf;
          BUSY_O <= 1'b0;
          INTR_OPEN_O <= 1'b1;
          state_r <= S_IDLE;
        end
        default:
        begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> rtl/bts_map.vh
// Offsets, field positions, reset values and codes of the block transfer / swap / trap unit
`ifndef BTS_MAP_VH
`define BTS_MAP_VH
`define BTS_OFF_CTRL 8'h00
`define BTS_OFF_STAT 8'h04
`define BTS_OFF_CSR 8'h08
`define BTS_OFF_SVSR 8'h0c
`define BTS_OFF_REGIDX 8'h10
`define BTS_OFF_REGDAT 8'h14
`define BTS_OFF_PC 8'h18
`define BTS_CTRL_BIG 0
`define BTS_STAT_BUSY 0
`define BTS_STAT_SVC 1
`define BTS_STAT_ABORT 2
`define BTS_CSR_RESET 32'h0000_00d3
`define BTS_MODE_SVC 5'h13
`define BTS_SWI_VECTOR 32'h0000_0008
`define BTS_CYC_IDLE 2'h0
`define BTS_CYC_N 2'h1
`define BTS_CYC_S 2'h2
`define BTS_CYC_I 2'h3
`define BTS_LINK_SVC 5'h10
`define BTS_PC_IDX 4'hf
`define BTS_LR_IDX 4'he
`endif

// >>> rtl/bts_regfile.v
// Register file: sixteen visible registers plus the supervisor link register, registered read
`timescale 1ns/1ps
module bts_regfile #(
  parameter DEPTH = 17,
  parameter AW = 5
) (
  // Clock
  input wire clk_i,
  // Write port
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [31:0] wdata_i,
  // Read port
  input wire [AW-1:0] raddr_i,
  output reg [31:0] rdata_o
);
  reg [31:0] mem [0:DEPTH-1];

  // Read is old data on a same-cycle write; the sequencer never needs the bypass
  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// >>> testbench/bts_exec_props.sv
// Concurrent checks on the execution unit ports
`timescale 1ns/1ps
module bts_exec_props (
  // Clock and reset
  input wire CLK_I,
  input wire RSTN_I,
  // Instruction side
  input wire [31:0] INSTR_I,
  input wire INSTR_VALID_I,
  input wire BUSY_O,
  input wire DONE_O,
  input wire INTR_OPEN_O,
  input wire TRAP_SWI_O,
  input wire TRAP_ABORT_O,
  input wire PC_LOAD_O,
  input wire [31:0] PC_O,
  // Memory side
  input wire MEM_REQ_O,
  input wire MEM_WRITE_O,
  input wire MEM_BYTE_O,
  input wire MEM_LOCK_O,
  input wire [1:0] MEM_CYCLE_O,
  input wire [31:0] MEM_ADDR_O,
  input wire MEM_ABORT_I
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  lock_pair_a: assert property (
    $rose(MEM_LOCK_O) |-> (MEM_REQ_O && !MEM_WRITE_O) ##1 (MEM_LOCK_O && MEM_REQ_O && MEM_WRITE_O) ##1 !MEM_LOCK_O)
    else $error("Lock does not cover exactly one read and one write");
  swap_same_addr_a: assert property (
    (MEM_LOCK_O && !MEM_WRITE_O) |=> (MEM_ADDR_O == $past(MEM_ADDR_O) && MEM_BYTE_O == $past(MEM_BYTE_O)))
    else $error("Swap write moved to another place or width");
  lock_no_intr_a: assert property (
    $rose(MEM_LOCK_O) |-> !INTR_OPEN_O [*2])
    else $error("Interrupt window open inside swap");
  swap_cycles_a: assert property (
    $rose(MEM_LOCK_O) |-> MEM_CYCLE_O == 2'h1 ##1 MEM_CYCLE_O == 2'h1 ##1 MEM_CYCLE_O == 2'h3
    ##1 MEM_CYCLE_O == 2'h2 ##1 DONE_O)
    else $error("Swap cycle sequence wrong");
  swi_entry_a: assert property (
    TRAP_SWI_O |-> (DONE_O && PC_O == 32'h8 && $past(PC_LOAD_O, 3) && $past(MEM_ADDR_O, 3) == 32'h8))
    else $error("Supervisor call did not reach the vector");
  swi_cycles_a: assert property (
    TRAP_SWI_O |-> ($past(MEM_CYCLE_O, 3) == 2'h1 && $past(MEM_CYCLE_O, 2) == 2'h2 && $past(MEM_CYCLE_O) == 2'h2))
    else $error("Supervisor call cycle types wrong");
  read_abort_a: assert property (
    (MEM_LOCK_O && !MEM_WRITE_O && MEM_ABORT_I) |-> ##4 TRAP_ABORT_O)
    else $error("Read abort of swap not trapped");
  write_abort_a: assert property (
    (MEM_LOCK_O && MEM_WRITE_O && MEM_ABORT_I) |-> ##3 TRAP_ABORT_O)
    else $error("Write abort of swap not trapped");
  cond_skip_a: assert property (
    (INSTR_VALID_I && !BUSY_O && INSTR_I[31:28] == 4'hf) |=> (DONE_O && !BUSY_O && !MEM_REQ_O && !TRAP_SWI_O))
    else $error("Failed condition still acted");
endmodule
bind bts_exec bts_exec_props u_props (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .INSTR_I(INSTR_I), .INSTR_VALID_I(INSTR_VALID_I), .BUSY_O(BUSY_O),
  .DONE_O(DONE_O), .INTR_OPEN_O(INTR_OPEN_O), .TRAP_SWI_O(TRAP_SWI_O), .TRAP_ABORT_O(TRAP_ABORT_O),
  .PC_LOAD_O(PC_LOAD_O), .PC_O(PC_O), .MEM_REQ_O(MEM_REQ_O), .MEM_WRITE_O(MEM_WRITE_O), .MEM_BYTE_O(MEM_BYTE_O),
  .MEM_LOCK_O(MEM_LOCK_O), .MEM_CYCLE_O(MEM_CYCLE_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_ABORT_I(MEM_ABORT_I)
);

// >>> testbench/bts_mem_model.sv
// Memory manager and memory model answering the execution unit
`timescale 1ns/1ps
module bts_mem_model (
  // Clock
  input wire clk_i,
  // Requests
  input wire req_i,
  input wire write_i,
  input wire byte_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  // Fault injection
  input wire abort_rd_i,
  input wire abort_wr_i,
  // Answer, given within the cycle of the request
  output wire [31:0] rdata_o,
  output wire abort_o
);
  reg [31:0] mem [0:63];
  reg [31:0] alog [0:15];
  reg wlog [0:15];
  integer nreq;
  integer i;
  initial
  begin
    nreq = 0;
    for (i = 0; i < 64; i = i + 1)
      mem[i] = 32'h5a00_0000 | (i * 4);
  end
  // Outside a read the data lines show the inverse, so a sample taken in the wrong cycle is caught
  assign rdata_o = (req_i && !write_i) ? mem[addr_i[7:2]] : ~mem[addr_i[7:2]];
  assign abort_o = req_i && (write_i ? abort_wr_i : abort_rd_i);
  // No arbitration here, so a locked pair is never split
  always @(posedge clk_i)
  begin
    if (req_i)
    begin
      alog[nreq[3:0]] <= addr_i;
      wlog[nreq[3:0]] <= write_i;
      nreq <= nreq + 1;
      // Aborted writes must not reach memory; a byte write touches its own lane only
      if (write_i && !abort_wr_i && byte_i)
        mem[addr_i[7:2]][{addr_i[1:0], 3'h0} +: 8] <= wdata_i[7:0];
      else if (write_i && !abort_wr_i)
        mem[addr_i[7:2]] <= wdata_i;
    end
  end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for supervisor call, swap and block transfers
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [31:0] instr = 32'h0;
  reg [31:0] ipc = 32'h0;
  reg ivalid = 1'b0;
  reg [7:0] baddr = 8'h0;
  reg [31:0] bwdata = 32'h0;
  reg bwr = 1'b0;
  reg brd = 1'b0;
  reg ab_rd = 1'b0;
  reg ab_wr = 1'b0;
  wire busy, done, iopen, tswi, tabt, pcld, mreq, mwr, mbyte, mlock, mabt;
  wire [31:0] pc, maddr, mwdata, mrdata, brdata;
  wire [1:0] mcyc;
  integer errors = 0;
  integer tests_run = 0;
  integer cycles = 0;
  integer lat, i, k;
  reg [31:0] d, a0;
  reg [95:0] rows [0:3];
  bts_exec dut (.CLK_I(clk), .RSTN_I(rstn), .INSTR_I(instr), .INSTR_PC_I(ipc), .INSTR_VALID_I(ivalid),
    .BUSY_O(busy), .DONE_O(done), .INTR_OPEN_O(iopen), .TRAP_SWI_O(tswi), .TRAP_ABORT_O(tabt),
    .PC_LOAD_O(pcld), .PC_O(pc), .MEM_REQ_O(mreq), .MEM_WRITE_O(mwr), .MEM_BYTE_O(mbyte), .MEM_LOCK_O(mlock),
    .MEM_CYCLE_O(mcyc), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwdata), .MEM_RDATA_I(mrdata), .MEM_ABORT_I(mabt),
    .BUS_ADDR_I(baddr), .BUS_WDATA_I(bwdata), .BUS_WR_I(bwr), .BUS_RD_I(brd), .BUS_RDATA_O(brdata));
  bts_mem_model mem_u (.clk_i(clk), .req_i(mreq), .write_i(mwr), .byte_i(mbyte), .addr_i(maddr), .wdata_i(mwdata),
    .abort_rd_i(ab_rd), .abort_wr_i(ab_wr), .rdata_o(mrdata), .abort_o(mabt));
  always #4 clk = ~clk;
  task finish_test;
    begin
      $display("Checks run %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // A hung handshake ends here rather than running forever
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      finish_test;
    end
  end
  task check(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus_wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk);
      baddr <= a;
      bwdata <= v;
      bwr <= 1'b1;
      @(posedge clk);
      bwr <= 1'b0;
    end
  endtask
  task bus_rd(input [7:0] a);
    begin
      @(posedge clk);
      baddr <= a;
      brd <= 1'b1;
      @(posedge clk);
      brd <= 1'b0;
      #1;
      d = brdata;
    end
  endtask
  task set_reg(input [31:0] idx, input [31:0] v);
    begin
      bus_wr(8'h10, idx);
      bus_wr(8'h14, v);
    end
  endtask
  task get_reg(input [31:0] idx);
    begin
      bus_wr(8'h10, idx);
      bus_rd(8'h14);
    end
  endtask
  // Latency counts from the taking edge; lat 1 means done in the next cycle
  task issue(input [31:0] ins, input [31:0] p);
    begin
      @(posedge clk);
      instr <= ins;
      ipc <= p;
      ivalid <= 1'b1;
      @(posedge clk);
      ivalid <= 1'b0;
      #1;
      lat = 1;
      while (done !== 1'b1 && lat < 40)
      begin
        @(posedge clk);
        #1;
        lat = lat + 1;
      end
    end
  endtask
  initial
  begin
    rows[0] = {32'hff00_0000, 32'h200, 32'd1};
    rows[1] = {32'h0f00_0000, 32'h204, 32'd1};
    rows[2] = {32'h1fab_cdef, 32'h300, 32'd4};
    rows[3] = {32'hef00_0000, 32'h400, 32'd4};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    check(busy, 1'b0);
    check(iopen, 1'b1);
    bus_rd(8'hfc);
    check(d, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      issue(rows[i][95:64], rows[i][63:32]);
      check(lat, rows[i][31:0]);
      check(tswi, rows[i][31:0] == 4);
      if (rows[i][31:0] == 4)
        check(pc, 32'h8);
    end
    get_reg(14);
    check(d, 32'h404);
    bus_wr(8'h08, 32'h2000_00d3);
    issue(32'hef00_0001, 32'h500);
    bus_wr(8'h08, 32'h0000_00d3);
    bus_rd(8'h0c);
    check(d, 32'h2000_00d3);
    issue(32'he1b0_f00e, 32'h8);
    check(pc, 32'h504);
    bus_rd(8'h08);
    check(d, 32'h2000_00d3);
    set_reg(2, 32'h40);
    set_reg(1, 32'hcafe_3311);
    set_reg(0, 32'h1111_1111);
    mem_u.mem[16] = 32'ha5a5_1234;
    issue(32'he102_0091, 32'h600);
    check(lat, 7);
    check(tabt, 1'b0);
    check(mem_u.mem[16], 32'hcafe_3311);
    get_reg(0);
    check(d, 32'ha5a5_1234);
    set_reg(2, 32'h41);
    set_reg(3, 32'hee);
    issue(32'he142_3093, 32'h604);
    check(mem_u.mem[16], 32'hcafe_ee11);
    get_reg(3);
    check(d, 32'h33);
    set_reg(2, 32'h40);
    for (i = 1; i < 4; i = i + 1)
    begin
      set_reg(0, 32'h77);
      mem_u.mem[16] = 32'h1234_5678;
      ab_rd <= i[0];
      ab_wr <= i[1];
      issue(32'he102_0091, 32'h700);
      check(tabt, 1'b1);
      ab_rd <= 1'b0;
      ab_wr <= 1'b0;
      get_reg(0);
      check(d, i[0] ? 32'h77 : 32'h1234_5678);
    end
    // Loads run first so they still see the fill pattern
    set_reg(4, 32'h80);
    for (i = 0; i < 8; i = i + 1)
    begin
      set_reg(1, 32'h11);
      set_reg(2, 32'h22);
      set_reg(5, 32'h55);
      mem_u.nreq = 0;
      issue({4'he, 3'b100, i[1], i[0], 2'b00, ~i[2], 4'h4, 16'h0026}, 32'h800);
      a0 = i[0] ? (i[1] ? 32'h84 : 32'h80) : (i[1] ? 32'h74 : 32'h78);
      for (k = 0; k < 3; k = k + 1)
      begin
        check(mem_u.alog[k], a0 + 4 * k);
        check(mem_u.wlog[k], i[2]);
      end
      if (i[2])
      begin
        check(mem_u.mem[a0[7:2]], 32'h11);
        check(mem_u.mem[a0[7:2] + 2], 32'h55);
      end
      else
      begin
        get_reg(5);
        check(d, 32'h5a00_0008 + a0);
      end
    end
    bus_wr(8'h0c, 32'h1000_00d3);
    mem_u.mem[32] = 32'h0000_0a00;
    issue(32'he8d4_8000, 32'h900);
    check(pc, 32'h0000_0a00);
    bus_rd(8'h08);
    check(d, 32'h1000_00d3);
    finish_test;
  end
endmodule
